// file: hdl/tap_consts.svh
/*
  Constants of the four-wire test access port: instruction codes, register
  widths, field positions, reset values and the clock ratio.
  Assumes it is included by bare name from the package, the pin checker and the bench.
*/
// What this block does
// - tdo changes on falling tck, shift states only
// - tdi sampled rising tck, lsb first
// - storage holds indefinitely while tck stopped low
// - tms sampled rising tck chooses next state
// - power-on reset: test-logic-reset, latch holds bypass
// - five tms-high edges reach test-logic-reset, stay
// - stray low tms recovered by three highs
// - capture-ir loads 001 into instruction shifter
// - shift-ir shifts lsb first; exit/pause hold
// - latch loads on falling tck in update-ir
// - codes 011, 101, 111 select one-cell bypass
// - codes 000, 001 keep previous data path
// - 010 selects debug register, 100 programming register
// - code 110 reserved, given no function
// - shift-dr moves one bit each tck
// - update-dr latches buffer, buffer reloads shifter
// - data scans never touch instruction registers
// - private instruction holds until update or reset
// - state changes only on rising tck edges
// - debug word is two status bits plus byte
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH

`define IR_W           3
`define IR_CAPTURE     3'h1
`define IR_EXTEST      3'h0
`define IR_SAMPLE      3'h1
`define IR_DEBUG       3'h2
`define IR_BYPASS_A    3'h3
`define IR_PROG        3'h4
`define IR_BYPASS_B    3'h5
`define IR_RESERVED    3'h6
`define IR_BYPASS_C    3'h7
`define IR_RESET_VAL   3'h3

`define DBG_W          10
`define PRG_W          3
`define DBG_STAT_LSB   0
`define DBG_STAT_W     2
`define DBG_BYTE_LSB   2
`define DBG_BYTE_W     8
`define BYP_CAPTURE    1'h0

`define TCK_MAX_RATIO  8

`endif

// file: hdl/tap_pkg.sv
/*
  Types of the test access port: controller states, data path selection and
  the state records of each clock domain.
  Assumes tap_consts.svh is on the include path.
*/
`include "tap_consts.svh"

package tap_pkg;

  typedef enum logic [15:0] {
    st_reset    = 16'h0001,
    st_idle     = 16'h0002,
    st_sel_dr   = 16'h0004,
    st_cap_dr   = 16'h0008,
    st_shift_dr = 16'h0010,
    st_exit1_dr = 16'h0020,
    st_pause_dr = 16'h0040,
    st_exit2_dr = 16'h0080,
    st_upd_dr   = 16'h0100,
    st_sel_ir   = 16'h0200,
    st_cap_ir   = 16'h0400,
    st_shift_ir = 16'h0800,
    st_exit1_ir = 16'h1000,
    st_pause_ir = 16'h2000,
    st_exit2_ir = 16'h4000,
    st_upd_ir   = 16'h8000
  } tap_state_t;

  typedef enum logic [2:0] {
    path_byp = 3'h1,
    path_dbg = 3'h2,
    path_prg = 3'h4
  } dr_path_t;

  // rising tck edge state
  typedef struct packed {
    tap_state_t             state;
    logic [`IR_W-1:0]       ir_sr;
    logic                   byp;
    logic [`DBG_W-1:0]      dbg_sr;
    logic [`PRG_W-1:0]      prg_sr;
  } rise_t;

  // falling tck edge state
  typedef struct packed {
    logic [`IR_W-1:0]       parallel_instruction_latch;
    dr_path_t               path;
    logic [`DBG_W-1:0]      dbg_buf;
    logic [`PRG_W-1:0]      prg_buf;
    logic                   tdo;
    logic                   tdo_oe_n;
    logic                   dbg_upd_tgl;
    logic                   prg_upd_tgl;
    logic                   load_meta;
    logic                   load_sync;
    logic                   load_ack;
  } fall_t;

  // system clock state
  typedef struct packed {
    logic                   dbg_meta;
    logic                   dbg_sync;
    logic                   dbg_seen;
    logic                   prg_meta;
    logic                   prg_sync;
    logic                   prg_seen;
    logic [`DBG_W-1:0]      dbg_rx;
    logic                   dbg_rx_valid;
    logic [`PRG_W-1:0]      prg_rx;
    logic                   prg_rx_valid;
    logic [`DBG_W-1:0]      tx_word;
    logic                   load_req;
    logic                   ack_meta;
    logic                   ack_sync;
    logic                   tx_busy;
    logic [1:0]             mode_meta;
    logic [1:0]             mode_sync;
  } sys_t;

endpackage

// file: hdl/tap_port.sv
/*
  Test access port controller with instruction register, one-cell bypass,
  ten-bit debug and three-bit programming data registers, and the crossing
  of their parallel buffers into the system clock domain.
  Assumes tck comes from the host and may stop low at any time; the system
  clock runs at least eight times faster than tck.
*/
`timescale 1ns/100ps

module tap_port
  import tap_pkg::*;
(
  // system clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // host link
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdo_oe_n,
  // received data registers, system side
  output logic [`DBG_W-1:0]      dbg_rx_data,
  output logic                   dbg_rx_valid,
  output logic [`PRG_W-1:0]      prg_rx_data,
  output logic                   prg_rx_valid,
  // outgoing debug word, system side
  input  wire logic [`DBG_W-1:0] dbg_tx_data,
  input  wire logic              dbg_tx_write,
  output logic                   dbg_tx_busy,
  // active private instruction, system side
  output logic                   dbg_mode,
  output logic                   prg_mode
);

  rise_t r_q;
  rise_t r_d;
  fall_t f_q;
  fall_t f_d;
  sys_t  s_q;
  sys_t  s_d;

  function automatic tap_state_t next_state(input tap_state_t st, input logic m);
    tap_state_t nx;
    nx = st_reset;
    case (st)
      st_reset:    nx = m ? st_reset    : st_idle;
      st_idle:     nx = m ? st_sel_dr   : st_idle;
      st_sel_dr:   nx = m ? st_sel_ir   : st_cap_dr;
      st_cap_dr:   nx = m ? st_exit1_dr : st_shift_dr;
      st_shift_dr: nx = m ? st_exit1_dr : st_shift_dr;
      st_exit1_dr: nx = m ? st_upd_dr   : st_pause_dr;
      st_pause_dr: nx = m ? st_exit2_dr : st_pause_dr;
      st_exit2_dr: nx = m ? st_upd_dr   : st_shift_dr;
      st_upd_dr:   nx = m ? st_sel_dr   : st_idle;
      st_sel_ir:   nx = m ? st_reset    : st_cap_ir;
      st_cap_ir:   nx = m ? st_exit1_ir : st_shift_ir;
      st_shift_ir: nx = m ? st_exit1_ir : st_shift_ir;
      st_exit1_ir: nx = m ? st_upd_ir   : st_pause_ir;
      st_pause_ir: nx = m ? st_exit2_ir : st_pause_ir;
      st_exit2_ir: nx = m ? st_upd_ir   : st_shift_ir;
      st_upd_ir:   nx = m ? st_sel_dr   : st_idle;
      default:     nx = st_reset;
    endcase
    return nx;
  endfunction

  // decode of an updated instruction; reserved and no-op codes keep the path
  function automatic dr_path_t decode_path(input logic [`IR_W-1:0] code,
                                           input dr_path_t        prev);
    dr_path_t p;
    p = prev;
    case (code)
      `IR_BYPASS_A,
      `IR_BYPASS_B,
      `IR_BYPASS_C: p = path_byp;
      `IR_DEBUG:    p = path_dbg;
      `IR_PROG:     p = path_prg;
      `IR_EXTEST,
      `IR_SAMPLE:   p = prev;
      `IR_RESERVED: p = prev;
      default:      p = prev;
    endcase
    return p;
  endfunction

  // rising tck: controller and shift registers
  always_comb begin
    r_d = r_q;
    r_d.state = next_state(r_q.state, tms);
    case (r_q.state)
      st_cap_ir: begin
        r_d.ir_sr = `IR_CAPTURE;
      end
      st_shift_ir: begin
        r_d.ir_sr = {tdi, r_q.ir_sr[`IR_W-1:1]};
      end
      st_cap_dr: begin
        // refresh from buffers so a system reload goes out on this scan
        r_d.byp    = `BYP_CAPTURE;
        r_d.dbg_sr = f_q.dbg_buf;
        r_d.prg_sr = f_q.prg_buf;
      end
      st_shift_dr: begin
        case (f_q.path)
          path_byp: r_d.byp    = tdi;
          path_dbg: r_d.dbg_sr = {tdi, r_q.dbg_sr[`DBG_W-1:1]};
          path_prg: r_d.prg_sr = {tdi, r_q.prg_sr[`PRG_W-1:1]};
          default:  r_d.byp    = tdi;
        endcase
      end
      st_upd_dr: begin
        // buffer latched on the falling edge is now the outgoing data
        r_d.dbg_sr = f_q.dbg_buf;
        r_d.prg_sr = f_q.prg_buf;
      end
      default: begin
        r_d.ir_sr = r_q.ir_sr;
      end
    endcase
  end

  // no register here moves without a tck edge, so a stopped clock holds all
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      r_q.state  <= st_reset;
      r_q.ir_sr  <= `IR_RESET_VAL;
      r_q.byp    <= 1'h0;
      r_q.dbg_sr <= '0;
      r_q.prg_sr <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // falling tck: latches, buffers, tdo and the load crossing
  always_comb begin
    f_d = f_q;
    f_d.load_meta = s_q.load_req;
    f_d.load_sync = f_q.load_meta;
    f_d.tdo       = 1'h1;
    f_d.tdo_oe_n  = 1'h1;
    case (r_q.state)
      st_reset: begin
        // held here by five or more high tms samples; a stray low recovers
        f_d.parallel_instruction_latch = `IR_RESET_VAL;
        f_d.path = path_byp;
      end
      st_upd_ir: begin
        f_d.parallel_instruction_latch = r_q.ir_sr;
        f_d.path = decode_path(r_q.ir_sr, f_q.path);
      end
      st_shift_ir: begin
        f_d.tdo      = r_q.ir_sr[0];
        f_d.tdo_oe_n = 1'h0;
      end
      st_shift_dr: begin
        f_d.tdo_oe_n = 1'h0;
        case (f_q.path)
          path_byp: f_d.tdo = r_q.byp;
          path_dbg: f_d.tdo = r_q.dbg_sr[0];
          path_prg: f_d.tdo = r_q.prg_sr[0];
          default:  f_d.tdo = r_q.byp;
        endcase
      end
      st_upd_dr: begin
        // data scans leave instruction latch and path untouched
        case (f_q.path)
          path_dbg: begin
            f_d.dbg_buf     = r_q.dbg_sr;
            f_d.dbg_upd_tgl = ~f_q.dbg_upd_tgl;
          end
          path_prg: begin
            f_d.prg_buf     = r_q.prg_sr;
            f_d.prg_upd_tgl = ~f_q.prg_upd_tgl;
          end
          default: begin
            f_d.dbg_buf = f_q.dbg_buf;
          end
        endcase
      end
      default: begin
        f_d.parallel_instruction_latch = f_q.parallel_instruction_latch;
      end
    endcase
    // system reload waits one edge if a debug update claims the buffer
    if (f_q.load_sync != f_q.load_ack &&
        !(r_q.state == st_upd_dr && f_q.path == path_dbg)) begin
      f_d.dbg_buf  = s_q.tx_word;
      f_d.load_ack = f_q.load_sync;
    end
  end

  always_ff @(negedge tck or posedge rst) begin
    if (rst) begin
      f_q.parallel_instruction_latch <= `IR_RESET_VAL;
      f_q.path        <= path_byp;
      f_q.dbg_buf     <= '0;
      f_q.prg_buf     <= '0;
      f_q.tdo         <= 1'h1;
      f_q.tdo_oe_n    <= 1'h1;
      f_q.dbg_upd_tgl <= 1'h0;
      f_q.prg_upd_tgl <= 1'h0;
      f_q.load_meta   <= 1'h0;
      f_q.load_sync   <= 1'h0;
      f_q.load_ack    <= 1'h0;
    end else begin
      f_q <= f_d;
    end
  end

  // system clock: update toggles in, reload handshake out, mode levels
  always_comb begin
    s_d = s_q;
    s_d.dbg_meta  = f_q.dbg_upd_tgl;
    s_d.dbg_sync  = s_q.dbg_meta;
    s_d.dbg_seen  = s_q.dbg_sync;
    s_d.prg_meta  = f_q.prg_upd_tgl;
    s_d.prg_sync  = s_q.prg_meta;
    s_d.prg_seen  = s_q.prg_sync;
    s_d.ack_meta  = f_q.load_ack;
    s_d.ack_sync  = s_q.ack_meta;
    s_d.mode_meta = {f_q.path == path_prg, f_q.path == path_dbg};
    s_d.mode_sync = s_q.mode_meta;
    s_d.dbg_rx_valid = 1'h0;
    s_d.prg_rx_valid = 1'h0;
    // buffers sit still for a whole tck period, far longer than the sync
    if (s_q.dbg_sync != s_q.dbg_seen) begin
      s_d.dbg_rx       = f_q.dbg_buf;
      s_d.dbg_rx_valid = 1'h1;
    end
    if (s_q.prg_sync != s_q.prg_seen) begin
      s_d.prg_rx       = f_q.prg_buf;
      s_d.prg_rx_valid = 1'h1;
    end
    if (s_q.tx_busy) begin
      if (s_q.ack_sync == s_q.load_req) begin
        s_d.tx_busy = 1'h0;
      end
    end else if (dbg_tx_write) begin
      // word is held until tck side acknowledges; writes while busy drop
      s_d.tx_word  = dbg_tx_data;
      s_d.load_req = ~s_q.load_req;
      s_d.tx_busy  = 1'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tdo          = f_q.tdo;
  assign tdo_oe_n     = f_q.tdo_oe_n;
  assign dbg_rx_data  = s_q.dbg_rx;
  assign dbg_rx_valid = s_q.dbg_rx_valid;
  assign prg_rx_data  = s_q.prg_rx;
  assign prg_rx_valid = s_q.prg_rx_valid;
  assign dbg_tx_busy  = s_q.tx_busy;
  assign dbg_mode     = s_q.mode_sync[0];
  assign prg_mode     = s_q.mode_sync[1];

endmodule

// file: sim/tap_port_props.sv
/*
  Pin checker of the test access port, bound to every tap_port.
  Assumes tck edges never coincide with clk edges.
*/
`timescale 1ns/100ps
`include "tap_consts.svh"

module tap_port_props (
  // clocks and reset
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              tck,
  // link
  input wire logic              tms,
  input wire logic              tdo,
  input wire logic              tdo_oe_n,
  // system side
  input wire logic [`DBG_W-1:0] dbg_rx_data,
  input wire logic              dbg_rx_valid,
  input wire logic              prg_rx_valid,
  input wire logic              dbg_tx_write,
  input wire logic              dbg_tx_busy,
  input wire logic              dbg_mode,
  input wire logic              prg_mode
);
  logic [2:0] hi_q;

  // run of high tms samples; starts at 5 since reset is the reset state
  always_ff @(posedge tck or posedge rst) begin
    if (rst)
      hi_q <= 3'h5;
    else if (!tms)
      hi_q <= 3'h0;
    else if (hi_q != 3'h7)
      hi_q <= hi_q + 3'h1;
  end

  tdo_on_fall_a: assert property (@(posedge clk) disable iff (rst)
    $changed(tdo) |-> $fell(tck)) else $error("tdo moved off falling tck");
  oe_on_fall_a: assert property (@(posedge clk) disable iff (rst)
    $changed(tdo_oe_n) |-> $fell(tck)) else $error("oe moved off falling tck");
  idle_level_a: assert property (@(posedge clk) disable iff (rst)
    tdo_oe_n |-> tdo) else $error("tdo low while released");
  tms_reset_a: assert property (@(posedge tck) disable iff (rst)
    hi_q >= 3'h5 |-> tdo_oe_n) else $error("not in reset after five highs");
  modes_clear_a: assert property (@(posedge tck) disable iff (rst)
    hi_q == 3'h7 |-> !dbg_mode && !prg_mode) else $error("mode kept in reset");
  modes_excl_a: assert property (@(posedge clk) disable iff (rst)
    !(dbg_mode && prg_mode)) else $error("two paths selected");
  dbg_pulse_a: assert property (@(posedge clk) disable iff (rst)
    dbg_rx_valid |=> !dbg_rx_valid) else $error("debug valid too long");
  prg_pulse_a: assert property (@(posedge clk) disable iff (rst)
    prg_rx_valid |=> !prg_rx_valid) else $error("prog valid too long");
  dbg_data_a: assert property (@(posedge clk) disable iff (rst)
    $changed(dbg_rx_data) |-> dbg_rx_valid) else $error("rx data without valid");
  tx_take_a: assert property (@(posedge clk) disable iff (rst)
    dbg_tx_write && !dbg_tx_busy |=> dbg_tx_busy) else $error("write not taken");
endmodule

bind tap_port tap_port_props tap_port_props_inst (.clk, .rst, .tck, .tms, .tdo,
  .tdo_oe_n, .dbg_rx_data, .dbg_rx_valid, .prg_rx_valid, .dbg_tx_write,
  .dbg_tx_busy, .dbg_mode, .prg_mode);

// file: sim/tap_host.sv
/*
  Host end of the link: drives tck, tms and tdi, samples tdo.
  Assumes calls start on a clk falling edge; tck stands low between frames.
*/
`timescale 1ns/100ps

module tap_host (
  // link out
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  // link in
  input  wire logic tdo,
  input  wire logic tdo_oe_n
);
  int   pause_at = -1;
  logic line;

  // weak pull-up when released
  assign line = tdo_oe_n ? 1'b1 : tdo;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // 125 ns tck, far below a eighth of the system clock
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62.5;
    o = line;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask

  // odd offset keeps tck edges clear of clk edges
  task automatic run(input logic [7:0] seq, input int n);
    logic o;
    #1.3;
    for (int i = 0; i < n; i++)
      step(seq[i], 1'b1, o);
  endtask

  // reset or idle, one scan lsb first, back to idle
  task automatic scan(input logic ir, input logic [9:0] din, input int n,
                      output logic [9:0] dout);
    logic o;
    #1.3;
    dout = '0;
    step(1'b0, 1'b1, o);
    step(1'b1, 1'b1, o);
    if (ir)
      step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      if (i == pause_at)
        #2000;
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
endmodule

// file: sim/test_jtag_tap_instruction_port.sv
/*
  Self-checking bench of tap_port with the host model on the link.
  Assumes tap_consts.svh and tap_pkg are compiled first.
*/
`timescale 1ns/100ps
`include "tap_consts.svh"
`define CHK(g, e) check(32'(g), 32'(e))

module test_jtag_tap_instruction_port
  import tap_pkg::*;
;
  logic              clk, rst, tck, tms, tdi, tdo, tdo_oe_n, dbg_mode, prg_mode;
  logic              dbg_rx_valid, prg_rx_valid, dbg_tx_write, dbg_tx_busy;
  logic [`DBG_W-1:0] dbg_rx_data, dbg_tx_data, dbuf, out;
  logic [`PRG_W-1:0] prg_rx_data, pbuf;
  dr_path_t          path;
  int                err_count = 0, n_compared = 0, n_dv = 0, n_pv = 0, e_dv = 0, e_pv = 0;
  logic [2:0]        codes [10] = '{3'h2, 3'h0, 3'h1, 3'h6, 3'h4, 3'h1, 3'h5, 3'h7, 3'h4, 3'h3};

  tap_port tap_port_inst (.clk, .rst, .tck, .tms, .tdi, .tdo, .tdo_oe_n, .dbg_rx_data,
    .dbg_rx_valid, .prg_rx_data, .prg_rx_valid, .dbg_tx_data, .dbg_tx_write,
    .dbg_tx_busy, .dbg_mode, .prg_mode);
  tap_host tap_host_inst (.tck, .tms, .tdi, .tdo, .tdo_oe_n);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (dbg_rx_valid === 1'b1)
      n_dv++;
    if (prg_rx_valid === 1'b1)
      n_pv++;
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_ir(input logic [2:0] code);
    @(negedge clk);
    tap_host_inst.scan(1'b1, {7'h0, code}, 3, out);
    `CHK(out, 10'h1);
    if (code == 3'h2)
      path = path_dbg;
    else if (code == 3'h4)
      path = path_prg;
    else if (code[0] && code != 3'h1)
      path = path_byp;
    `CHK({dbg_mode, prg_mode}, {path == path_dbg, path == path_prg});
  endtask

  task automatic do_dr(input logic [9:0] din);
    int         n;
    logic [9:0] e;
    n = path == path_dbg ? 10 : path == path_prg ? 3 : 4;
    e = path == path_dbg ? dbuf : path == path_prg ? {7'h0, pbuf} : {6'h0, din[2:0], 1'b0};
    @(negedge clk);
    tap_host_inst.scan(1'b0, din, n, out);
    `CHK(out, e);
    if (path == path_dbg) begin
      dbuf = din;
      e_dv++;
      `CHK(dbg_rx_data, din);
    end
    if (path == path_prg) begin
      pbuf = din[2:0];
      e_pv++;
      `CHK(prg_rx_data, din[2:0]);
    end
    `CHK({dbg_mode, prg_mode}, {path == path_dbg, path == path_prg});
  endtask

  task automatic t_reset();
    `CHK({tdo, tdo_oe_n, dbg_mode, prg_mode}, 4'hc);
    do_dr(10'h00b);
  endtask

  task automatic t_codes();
    for (int i = 0; i < 10; i++) begin
      do_ir(codes[i]);
      do_dr(10'h2a5 ^ 10'(i * 57));
    end
  endtask

  // second write lands while busy and must be dropped
  task automatic t_tx();
    do_ir(3'h2);
    @(negedge clk);
    dbg_tx_data = 10'h35a;
    dbg_tx_write = 1'b1;
    @(negedge clk);
    dbg_tx_data = 10'h0c3;
    `CHK(dbg_tx_busy, 1'b1);
    @(negedge clk);
    dbg_tx_write = 1'b0;
    tap_host_inst.run(8'h0, 4);
    repeat (8) @(negedge clk);
    `CHK(dbg_tx_busy, 1'b0);
    dbuf = 10'h35a;
    do_dr(10'h1f0);
  endtask

  task automatic t_stall();
    tap_host_inst.pause_at = 4;
    do_dr(10'h2c7);
    tap_host_inst.pause_at = -1;
  endtask

  task automatic t_tap_reset();
    @(negedge clk);
    tap_host_inst.run(8'hff, 7);
    path = path_byp;
    `CHK({dbg_mode, prg_mode}, 2'h0);
    @(negedge clk);
    tap_host_inst.run(8'h0e, 4);
    do_dr(10'h00d);
    do_ir(3'h1);
  endtask

  initial begin
    rst = 1'b1;
    dbg_tx_data = '0;
    dbg_tx_write = 1'b0;
    path = path_byp;
    dbuf = '0;
    pbuf = '0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_codes();
    t_tx();
    t_stall();
    t_tap_reset();
    `CHK(n_dv, e_dv);
    `CHK(n_pv, e_pv);
    close_out();
  end

  // whole run takes about 41 us
  initial begin
    #300000;
    err_count++;
    close_out();
  end
endmodule
